/* design/madc_pkg.sv */
// Package of constants and types for the monitor converter control and readback block.
package madc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] MADC_ADDR_SEQ_CTRL = 8'h14; // Sequence control register.
    localparam logic [7:0] MADC_ADDR_IN_SEL = 8'h15; // Input select register.
    localparam logic [7:0] MADC_ADDR_BAT_HI = 8'h16; // Battery result bits 9:2.
    localparam logic [7:0] MADC_ADDR_BAT_LO = 8'h17; // Battery result bits 1:0.
    localparam logic [7:0] MADC_ADDR_BST_HI = 8'h18; // Boost result bits 9:2.
    localparam logic [7:0] MADC_ADDR_BST_LO = 8'h19; // Boost result bits 1:0.
    localparam logic [7:0] MADC_ADDR_T1_HI = 8'h1a; // First temperature bits 9:2.
    localparam logic [7:0] MADC_ADDR_T1_LO = 8'h1b; // First temperature bits 1:0.
    localparam logic [7:0] MADC_ADDR_T2_HI = 8'h1c; // Second temperature bits 9:2.
    localparam logic [7:0] MADC_ADDR_T2_LO = 8'h1d; // Second temperature bits 1:0.

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] MADC_SEQ_CTRL_RST = 8'h32; // Interval 3, mode 1, powered down.
    localparam logic [7:0] MADC_IN_SEL_RST = 8'h04; // Battery enabled only.
    localparam logic [9:0] MADC_RESULT_RST = 10'h000; // Result reset value.
    localparam logic [7:0] MADC_ZERO_BYTE = 8'h00; // Read value of unmapped offsets.

    // ****************************************************************
    // Channel indices, in fixed scan order
    // ****************************************************************
    localparam int MADC_NCH = 4; // Number of measured channels.
    localparam logic [1:0] MADC_CH_BAT = 2'h0; // Battery channel.
    localparam logic [1:0] MADC_CH_BST = 2'h1; // Boost channel.
    localparam logic [1:0] MADC_CH_T1 = 2'h2; // First temperature channel.
    localparam logic [1:0] MADC_CH_T2 = 2'h3; // Second temperature channel.
    localparam logic [1:0] MADC_CH_LAST = 2'h3; // Last channel of a scan.

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int MADC_CLK_MHZ = 250; // System clock rate in MHz.
    localparam int MADC_RPT_US_0 = 0; // Interval code 0 in us.
    localparam int MADC_RPT_US_1 = 50; // Interval code 1 in us.
    localparam int MADC_RPT_US_2 = 250; // Interval code 2 in us.
    localparam int MADC_RPT_US_3 = 1000; // Interval code 3 in us.
    localparam int MADC_RPT_US_4 = 5000; // Interval code 4 in us.
    localparam int MADC_RPT_US_5 = 25000; // Interval code 5 in us.
    localparam int MADC_RPT_US_6 = 100000; // Interval code 6 in us.
    localparam int MADC_RPT_US_7 = 1000000; // Interval code 7 in us.
    localparam logic [31:0] MADC_ONE_CYC = 32'h0000_0001; // Smallest wait count.

    // ****************************************************************
    // Enumerations and carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        MADC_MODE_ONESHOT,
        MADC_MODE_REPEAT,
        MADC_MODE_DSP,
        MADC_MODE_RSVD
    } madc_mode_type;

    typedef enum logic [2:0] {
        MADC_ST_IDLE,
        MADC_ST_START,
        MADC_ST_WAITCONV,
        MADC_ST_NEXT,
        MADC_ST_INTERVAL,
        MADC_ST_DONE
    } madc_state_type;

    // Layout of the sequence control register.
    typedef struct packed {
        logic rsvd;
        logic [2:0] repeat_interval_sel;
        logic readback_update_halt;
        madc_mode_type converter_op_mode;
        logic converter_power_on;
    } madc_seq_ctrl_type;

    // Layout of the input select register.
    typedef struct packed {
        logic [4:0] rsvd;
        logic battery_meas_en;
        logic boost_meas_en;
        logic temperature_meas_en;
    } madc_in_sel_type;

    // Request to the analog converter.
    typedef struct packed {
        logic start;
        logic [1:0] channel;
    } madc_conv_req_type;

endpackage

/* design/madc_control.sv */
// Monitor converter sequencing, control registers and result readback.
// Behaviour
// - Interval field bits 6-4 selects scan spacing.
// - Halt bit freezes readback result registers.
// - Mode field picks one-shot, scan, DSP.
// - Bit 0 powers converter up or down.
// - Battery bit enables battery channel conversion.
// - Boost bit enables boost channel conversion.
// - Temperature bit enables both temperature channels.
// - Battery result split over 0x16, 0x17.
// - Boost result split over 0x18, 0x19.
// - First temperature split over 0x1A, 0x1B.
// - Second temperature high bits at 0x1C.
// - Second temperature low bits at 0x1D.
module madc_control
    import madc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Register control port, single-cycle strobes.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    // Trigger pulse from the on-chip DSP.
    input wire logic dsp_trigger,
    // Analog converter interface.
    output logic converter_power_on,
    output madc_conv_req_type conv_req,
    input wire logic conv_done,
    input wire logic [9:0] conv_data
);

    // ****************************************************************
    // Interval counts in cycles
    // ****************************************************************
    localparam logic [31:0] RPT_CYC [8] = '{
        32'(MADC_RPT_US_0 * MADC_CLK_MHZ), 32'(MADC_RPT_US_1 * MADC_CLK_MHZ),
        32'(MADC_RPT_US_2 * MADC_CLK_MHZ), 32'(MADC_RPT_US_3 * MADC_CLK_MHZ),
        32'(MADC_RPT_US_4 * MADC_CLK_MHZ), 32'(MADC_RPT_US_5 * MADC_CLK_MHZ),
        32'(MADC_RPT_US_6 * MADC_CLK_MHZ), 32'(MADC_RPT_US_7 * MADC_CLK_MHZ)};

    // ****************************************************************
    // State
    // ****************************************************************
    madc_seq_ctrl_type seq_ctrl_ff, nxt_seq_ctrl; // Sequence control register.
    madc_in_sel_type in_sel_ff, nxt_in_sel; // Input select register.
    logic [9:0] result_ff [MADC_NCH]; // Readback results per channel.
    logic [9:0] nxt_result [MADC_NCH]; // Next readback results.
    madc_state_type state_ff, nxt_state; // Sequencer state.
    logic [1:0] chan_ff, nxt_chan; // Channel being converted.
    logic [31:0] wait_ff, nxt_wait; // Interval countdown.
    logic [7:0] rd_data_ff, nxt_rd_data; // Registered read data.
    logic ctrl_rewrite; // Sequence control register written.
    logic [MADC_NCH-1:0] chan_en; // Per-channel enable.

    // Channel enables; both temperature channels share one bit.
    assign chan_en[MADC_CH_BAT] = in_sel_ff.battery_meas_en;
    assign chan_en[MADC_CH_BST] = in_sel_ff.boost_meas_en;
    assign chan_en[MADC_CH_T1] = in_sel_ff.temperature_meas_en;
    assign chan_en[MADC_CH_T2] = in_sel_ff.temperature_meas_en;
    assign ctrl_rewrite = reg_wr_en && (reg_addr == MADC_ADDR_SEQ_CTRL);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Only the two control registers are writable; result offsets ignore writes.
    always_comb begin
        nxt_seq_ctrl = seq_ctrl_ff;
        nxt_in_sel = in_sel_ff;
        if (ctrl_rewrite) begin
            nxt_seq_ctrl = madc_seq_ctrl_type'(reg_wr_data);
        end
        if (reg_wr_en && (reg_addr == MADC_ADDR_IN_SEL)) begin
            nxt_in_sel = madc_in_sel_type'(reg_wr_data);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seq_ctrl_ff <= madc_seq_ctrl_type'(MADC_SEQ_CTRL_RST);
            in_sel_ff <= madc_in_sel_type'(MADC_IN_SEL_RST);
        end else begin
            seq_ctrl_ff <= nxt_seq_ctrl;
            in_sel_ff <= nxt_in_sel;
        end
    end

    // Converter power follows bit 0 directly.
    assign converter_power_on = seq_ctrl_ff.converter_power_on;

    // ****************************************************************
    // Scan sequencer
    // ****************************************************************
    // Walks the channels in fixed order, skipping disabled ones.
    always_comb begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_wait = wait_ff;
        conv_req.start = 1'b0;
        conv_req.channel = chan_ff;
        if (!seq_ctrl_ff.converter_power_on || ctrl_rewrite) begin
            // Power-down or any sequence control write aborts and restarts the sequence.
            nxt_state = MADC_ST_IDLE;
            nxt_chan = MADC_CH_BAT;
        end else begin
            case (state_ff)
                MADC_ST_IDLE: begin
                    nxt_chan = MADC_CH_BAT;
                    case (seq_ctrl_ff.converter_op_mode)
                        MADC_MODE_ONESHOT: nxt_state = MADC_ST_START;
                        MADC_MODE_REPEAT: nxt_state = MADC_ST_START;
                        MADC_MODE_DSP: begin
                            // One scan per trigger pulse.
                            if (dsp_trigger) begin
                                nxt_state = MADC_ST_START;
                            end
                        end
                        default: nxt_state = MADC_ST_IDLE; // Reserved mode stays idle.
                    endcase
                end
                MADC_ST_START: begin
                    if (chan_en[chan_ff]) begin
                        conv_req.start = 1'b1;
                        nxt_state = MADC_ST_WAITCONV;
                    end else begin
                        nxt_state = MADC_ST_NEXT;
                    end
                end
                MADC_ST_WAITCONV: begin
                    if (conv_done) begin
                        nxt_state = MADC_ST_NEXT;
                    end
                end
                MADC_ST_NEXT: begin
                    if (chan_ff == MADC_CH_LAST) begin
                        // Scan complete; choose what follows by mode.
                        if (seq_ctrl_ff.converter_op_mode == MADC_MODE_REPEAT) begin
                            nxt_wait = RPT_CYC[seq_ctrl_ff.repeat_interval_sel];
                            nxt_state = MADC_ST_INTERVAL;
                        end else if (seq_ctrl_ff.converter_op_mode == MADC_MODE_DSP) begin
                            nxt_state = MADC_ST_IDLE;
                        end else begin
                            nxt_state = MADC_ST_DONE;
                        end
                    end else begin
                        nxt_chan = chan_ff + 2'h1;
                        nxt_state = MADC_ST_START;
                    end
                end
                MADC_ST_INTERVAL: begin
                    // Count down the repeat interval, then rescan.
                    if (wait_ff <= MADC_ONE_CYC) begin
                        nxt_chan = MADC_CH_BAT;
                        nxt_state = MADC_ST_START;
                    end else begin
                        nxt_wait = wait_ff - MADC_ONE_CYC;
                    end
                end
                MADC_ST_DONE: nxt_state = MADC_ST_DONE;
                default: nxt_state = MADC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= MADC_ST_IDLE;
            chan_ff <= MADC_CH_BAT;
            wait_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            wait_ff <= nxt_wait;
        end
    end

    // ****************************************************************
    // Result capture
    // ****************************************************************
    // A finished conversion updates its result unless readback is halted.
    for (genvar gi = 0; gi < MADC_NCH; gi++) begin : g_res
        always_comb begin
            nxt_result[gi] = result_ff[gi];
            if ((state_ff == MADC_ST_WAITCONV) && conv_done && (chan_ff == 2'(gi))
                    && !seq_ctrl_ff.readback_update_halt) begin
                nxt_result[gi] = conv_data;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                result_ff[gi] <= MADC_RESULT_RST;
            end else begin
                result_ff[gi] <= nxt_result[gi];
            end
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Read data is registered one cycle after the read strobe.
    always_comb begin
        nxt_rd_data = rd_data_ff;
        if (reg_rd_en) begin
            case (reg_addr)
                MADC_ADDR_SEQ_CTRL: nxt_rd_data = seq_ctrl_ff;
                MADC_ADDR_IN_SEL: nxt_rd_data = in_sel_ff;
                MADC_ADDR_BAT_HI: nxt_rd_data = result_ff[MADC_CH_BAT][9:2];
                MADC_ADDR_BAT_LO: nxt_rd_data = {result_ff[MADC_CH_BAT][1:0], 6'h00};
                MADC_ADDR_BST_HI: nxt_rd_data = result_ff[MADC_CH_BST][9:2];
                MADC_ADDR_BST_LO: nxt_rd_data = {result_ff[MADC_CH_BST][1:0], 6'h00};
                MADC_ADDR_T1_HI: nxt_rd_data = result_ff[MADC_CH_T1][9:2];
                MADC_ADDR_T1_LO: nxt_rd_data = {result_ff[MADC_CH_T1][1:0], 6'h00};
                MADC_ADDR_T2_HI: nxt_rd_data = result_ff[MADC_CH_T2][9:2];
                MADC_ADDR_T2_LO: nxt_rd_data = {result_ff[MADC_CH_T2][1:0], 6'h00};
                default: nxt_rd_data = MADC_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_ff <= MADC_ZERO_BYTE;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign reg_rd_data = rd_data_ff;

endmodule

/* verif/madc_control_asserts.sv */
// Checker of the monitor converter control block, bound to its ports.
module madc_control_asserts
    import madc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Register port.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    // Trigger and converter side.
    input wire logic dsp_trigger,
    input wire logic converter_power_on,
    input wire madc_conv_req_type conv_req,
    input wire logic conv_done,
    input wire logic [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] ctl_ff, nxt_ctl, sel_ff, nxt_sel; // Shadows of the two control registers.
    // ****************************************************************
    // Shadow registers
    // ****************************************************************
    // Follows every accepted write so reads and sequencing can be judged.
    always_comb begin
        nxt_ctl = (reg_wr_en && reg_addr == MADC_ADDR_SEQ_CTRL) ? reg_wr_data : ctl_ff;
        nxt_sel = (reg_wr_en && reg_addr == MADC_ADDR_IN_SEL) ? reg_wr_data : sel_ff;
    end
    // Registers the shadows, with the documented reset values.
    always_ff @(posedge sys_clk) begin
        ctl_ff <= rst ? MADC_SEQ_CTRL_RST : nxt_ctl;
        sel_ff <= rst ? MADC_IN_SEL_RST : nxt_sel;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_rd_seq; reg_rd_en && reg_addr == MADC_ADDR_SEQ_CTRL |=> reg_rd_data == $past(ctl_ff); endproperty
    a_rd_seq: assert property (p_rd_seq) else $error("sequence control readback wrong");
    property p_rd_sel; reg_rd_en && reg_addr == MADC_ADDR_IN_SEL |=> reg_rd_data == $past(sel_ff); endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("input select readback wrong");
    property p_rsvd; reg_rd_en && reg_addr inside {8'h17, 8'h19, 8'h1b, 8'h1d} |=> reg_rd_data[5:0] == 6'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved result bits not zero");
    property p_pwr; converter_power_on == ctl_ff[0]; endproperty
    a_pwr: assert property (p_pwr) else $error("power output differs from control bit");
    property p_off; !ctl_ff[0] || ctl_ff[2:1] == 2'h3 |-> !conv_req.start; endproperty
    a_off: assert property (p_off) else $error("conversion started while off or reserved mode");
    property p_start_en; conv_req.start |-> sel_ff[conv_req.channel == 2'h0 ? 2 : conv_req.channel == 2'h1 ? 1 : 0]; endproperty
    a_start_en: assert property (p_start_en) else $error("disabled channel converted");
    property p_pulse; conv_req.start |=> !conv_req.start; endproperty
    a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
    property p_hold; conv_req.start && !reg_wr_en |=> $stable(conv_req.channel); endproperty
    a_hold: assert property (p_hold) else $error("channel moved during conversion");
    property p_first; reg_wr_en && reg_addr == 8'h14 && reg_wr_data[0] && !reg_wr_data[2] && sel_ff[2:0] != 3'h0
        |=> ##[1:12] conv_req.start; endproperty
    a_first: assert property (p_first) else $error("scan did not begin after power up");
    c_dsp: cover property (conv_req.start && ctl_ff[2:1] == 2'h2);
    c_halt: cover property (conv_done && ctl_ff[3]);
    c_temp: cover property (conv_req.start && conv_req.channel == MADC_CH_T2);
endmodule

bind madc_control madc_control_asserts madc_control_asserts_i (.sys_clk(sys_clk), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .dsp_trigger(dsp_trigger), .converter_power_on(converter_power_on),
    .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data));

/* verif/madc_conv_model.sv */
// Behavioural model of the analog monitor converter behind the control block.
module madc_conv_model
    import madc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Requests and the value each channel measures.
    input wire logic converter_power_on,
    input wire madc_conv_req_type conv_req,
    input wire logic slow,
    input wire logic [3:0][9:0] chan_val,
    // Answer to the control block.
    output logic conv_done,
    output logic [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy_ff; // A conversion is in flight.
    logic [1:0] ch_ff; // Channel being converted.
    logic [3:0] wait_ff; // Cycles left before the answer.
    // Answers a start after one or ten cycles; data toggles when not valid, held at 0x155 while off or in reset.
    always @(posedge sys_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (rst || !converter_power_on) begin
            busy_ff <= 1'b0;
            conv_data <= 10'h155;
        end else if (conv_req.start) begin
            busy_ff <= 1'b1;
            ch_ff <= conv_req.channel;
            wait_ff <= slow ? 4'h9 : 4'h0;
        end else if (busy_ff && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= chan_val[ch_ff];
        end
    end
endmodule

/* verif/madc_control_tb.sv */
// Self-checking bench of the monitor converter control block.
module madc_control_tb
    import madc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t read got %h expected %h", $time, got, exp); end end
    logic sys_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, dsp_trigger = 1'b0, slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
    logic converter_power_on, conv_done, rd_pend = 1'b0;
    logic [9:0] conv_data;
    logic [3:0][9:0] chan_val = '0, exp_res = '0; // Measured values and expected results.
    madc_conv_req_type conv_req;
    logic [7:0] exp_q [$]; // Expected read data, oldest first.
    logic [7:0] exp_rd; // Oldest expectation, taken off the queue once per read.
    logic [31:0] lfsr = 32'h0001_3bda;
    int n_errors = 0, checked = 0, cyc = 0;
    madc_control madc_control_i (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .dsp_trigger(dsp_trigger),
        .converter_power_on(converter_power_on), .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data));
    madc_conv_model madc_conv_model_i (.sys_clk(sys_clk), .rst(rst), .converter_power_on(converter_power_on),
        .conv_req(conv_req), .slow(slow), .chan_val(chan_val), .conv_done(conv_done), .conv_data(conv_data));
    // ****************************************************************
    // Clock, timeout and read monitor
    // ****************************************************************
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Cuts a hang short well beyond the longest test.
    always @(posedge sys_clk) begin
        cyc++;
        rd_pend <= reg_rd_en;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    // Read data stands from the cycle after the read edge.
    always @(negedge sys_clk) begin
        if (rd_pend) begin
            // Pop once; the macro names its expected value twice.
            exp_rd = exp_q.pop_front();
            `CHK(reg_rd_data, exp_rd)
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // One write or read; for a read, d is the expected data.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr_en = wr;
        reg_rd_en = !wr;
        reg_addr = a;
        reg_wr_data = d;
        if (!wr) exp_q.push_back(d);
        @(posedge sys_clk);
        #1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    endtask
    // Reads all result registers against the expected results.
    task automatic chk_res();
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'h16 + 8'(2 * i), exp_res[i][9:2]);
            bus(1'b0, 8'h17 + 8'(2 * i), {exp_res[i][1:0], 6'h00});
        end
    endtask
    // Gives every channel a fresh random measured value.
    task automatic new_vals();
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            chan_val[i] = lfsr[9:0];
        end
    endtask
    // Copies the values of the channels enabled by mask m into the expectations.
    task automatic take(input logic [2:0] m);
        for (int i = 0; i < 4; i++) if (m[i == 0 ? 2 : i == 1 ? 1 : 0]) exp_res[i] = chan_val[i];
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        bus(1'b1, MADC_ADDR_BAT_HI, 8'hff);
        bus(1'b0, MADC_ADDR_SEQ_CTRL, MADC_SEQ_CTRL_RST);
        bus(1'b0, MADC_ADDR_IN_SEL, MADC_IN_SEL_RST);
        chk_res();
        bus(1'b0, 8'h1e, MADC_ZERO_BYTE);
        lfsr = lfsr_next(lfsr);
        bus(1'b1, MADC_ADDR_IN_SEL, lfsr[7:0]);
        bus(1'b0, MADC_ADDR_IN_SEL, lfsr[7:0]);
        $display("test reset_and_access done");
        slow = 1'b1;
        new_vals();
        bus(1'b1, MADC_ADDR_IN_SEL, 8'h07);
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h01);
        repeat (80) @(posedge sys_clk);
        take(3'h7);
        new_vals();
        repeat (80) @(posedge sys_clk);
        chk_res();
        $display("test one_shot done");
        slow = 1'b0;
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h03);
        repeat (40) @(posedge sys_clk);
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h0b);
        take(3'h7);
        new_vals();
        repeat (60) @(posedge sys_clk);
        chk_res();
        $display("test halt done");
        for (int k = 0; k < 3; k++) begin
            new_vals();
            bus(1'b1, MADC_ADDR_IN_SEL, 8'h01 << k);
            bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h01);
            repeat (80) @(posedge sys_clk);
            take(3'h1 << k);
            chk_res();
        end
        $display("test input_enables done");
        bus(1'b1, MADC_ADDR_IN_SEL, 8'h07);
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h05);
        new_vals();
        repeat (40) @(posedge sys_clk);
        chk_res();
        dsp_trigger = 1'b1;
        @(posedge sys_clk);
        #1;
        dsp_trigger = 1'b0;
        repeat (40) @(posedge sys_clk);
        take(3'h7);
        chk_res();
        $display("test dsp_trigger done");
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h13);
        repeat (40) @(posedge sys_clk);
        take(3'h7);
        new_vals();
        repeat (6000) @(posedge sys_clk);
        chk_res();
        repeat (8000) @(posedge sys_clk);
        take(3'h7);
        chk_res();
        $display("test repeat_interval done");
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h07);
        new_vals();
        repeat (40) @(posedge sys_clk);
        bus(1'b1, MADC_ADDR_SEQ_CTRL, 8'h82);
        repeat (40) @(posedge sys_clk);
        bus(1'b0, MADC_ADDR_SEQ_CTRL, 8'h82);
        chk_res();
        $display("test reserved_mode_and_off done");
        summarize();
    end
endmodule
